//--- hw/flash_ecc_fault_injection.sv
// flash ecc: hamming encode on write, correct/detect on read, fault inject
// assumes the flash array answers a read in the cycle of the request
`timescale 1ns/10ps
`default_nettype none
`include "flash_ecc_map.svh"

// Function
// [R1] error correction is always on; nothing disables it
// [R2] each 48-bit word pair written gets a 7-bit hamming parity
// [R3] stored block is 48 data plus parity; parity not software visible
// [R4] on read, recompute parity and correct a single-bit error
// [R5] on a double-bit error the read data pass unmodified
// [R6] corrected single error sets flag bit 12; enabled flag raises irq
// [R7] low status: calculated parity bits 15-8, read parity bits 7-0
// [R8] syndrome gives error position; zero and equal parities when clean
// [R9] double error raises hard trap and sets flag bit 1
// [R10] double error without trap handler also requests device reset
// [R11] high status: calculated double parity bit 9, read bit 8
// [R12] single or double faults injectable on read or write path
// [R13] read injection alters fetched data before the correction logic
// [R14] write injection alters data before they are stored
// [R15] software loads address, pointers, unlocks, enables, then accesses
// [R16] a fault inverts the data bit chosen by a pointer
// [R17] pointer 0 to 55 inverts that bit; 56 and above inject nothing
// [R18] for a single fault software writes all ones to pointer two
// [R19] compare address: bits 15:0 low register, 23:16 high register
// [R20] control bit 0 enables injection; other bits read zero
// [R21] key register takes low 8 bits, write only, reads zero
// [R22] unlock is key write 55h then aah before setting enable
// [R23] injection only on matching address while enable stays set
module flash_ecc_fault_injection (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic rd_req,
	input wire logic [23:0] rd_addr,
	input wire logic [55:0] rd_codeword,
	output logic rd_valid,
	output logic [47:0] rd_data,
	input wire logic wr_req,
	input wire logic [23:0] wr_addr,
	input wire logic [47:0] wr_data,
	output logic array_we,
	output logic [23:0] array_addr,
	output logic [55:0] array_codeword,
	input wire logic trap_handler_present,
	output logic single_error_irq,
	output logic hard_trap,
	output logic device_reset_request
);
	// ==========================================================
	// hamming and fault mask helpers
	function automatic logic [6:0] hamming(input logic [47:0] d);
		logic [6:0] c;
		int k;
		c = 7'h00;
		k = 0;
		for (int p = 1; p < 55; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (d[k])
					c = c ^ 7'(p);
				k++;
			end
		end
		return c;
	endfunction : hamming

	function automatic logic [47:0] fix_mask(input logic [6:0] syn);
		logic [47:0] m;
		int k;
		m = 48'h000000000000;
		k = 0;
		for (int p = 1; p < 55; p++) begin
			if ((p & (p - 1)) != 0) begin
				m[k] = (7'(p) == syn);
				k++;
			end
		end
		return m;
	endfunction : fix_mask

	function automatic logic [55:0] fault_mask(input logic [7:0] ptr);
		logic [55:0] m;
		m = 56'h00000000000000;
		if (ptr <= `LAST_FAULT_BIT)
			m[ptr[5:0]] = 1'b1;
		return m;
	endfunction : fault_mask

	// ==========================================================
	// state
	flash_ecc_pkg::state_t s;
	flash_ecc_pkg::state_t next_s;

	logic [55:0] inject_bits;
	logic rd_hit;
	logic wr_hit;
	logic [55:0] cw;
	logic [6:0] calc_sec;
	logic [6:0] syn;
	logic calc_ded;
	logic odd;
	logic err_single;
	logic err_double;
	logic [6:0] wr_sec;
	logic setup;
	logic wr_access;
	logic [31:0] rdata;
	logic known;

	// ==========================================================
	// datapath
	always_comb begin
		inject_bits = fault_mask(s.first_fault_pointer) ^
			fault_mask(s.second_fault_pointer); // R16 R17
		rd_hit = s.inject_enable && rd_req &&
			rd_addr == s.inject_compare_address; // R23
		wr_hit = s.inject_enable && wr_req &&
			wr_addr == s.inject_compare_address; // R23
		cw = rd_codeword ^ (rd_hit ? inject_bits : 56'h0); // R12 R13
		calc_sec = hamming(cw[47:0]); // R1 R4
		syn = calc_sec ^ cw[54:48]; // R8
		calc_ded = ^{cw[47:0], cw[54:48]};
		odd = calc_ded ^ cw[55];
		err_single = odd; // R4
		err_double = !odd && syn != 7'h00; // R5 R9
		wr_sec = hamming(wr_data); // R2
		setup = psel && !penable && !s.pready;
		wr_access = psel && penable && pwrite && s.pready;
	end

	// ==========================================================
	// register read mux
	always_comb begin
		rdata = 32'h00000000;
		known = 1'b1;
		case (paddr)
			`OFS_UNLOCK_KEY: rdata = 32'h00000000; // R21
			`OFS_INJECT_CONTROL:
				rdata[`BIT_INJECT_ENABLE] = s.inject_enable; // R20
			`OFS_INJECT_POINTERS:
				rdata[15:0] = {s.second_fault_pointer,
					s.first_fault_pointer};
			`OFS_INJECT_ADDR_LOW:
				rdata[15:0] = s.inject_compare_address[15:0]; // R19
			`OFS_INJECT_ADDR_HIGH:
				rdata[7:0] = s.inject_compare_address[23:16]; // R19
			`OFS_SINGLE_PARITY_STATUS:
				rdata[15:0] = {s.calc_single_parity,
					s.read_single_parity}; // R7
			`OFS_DOUBLE_SYNDROME_STATUS: begin
				rdata[`BIT_CALC_DOUBLE] = s.calc_double_parity; // R11
				rdata[`BIT_READ_DOUBLE] = s.read_double_parity; // R11
				rdata[7:0] = s.error_syndrome; // R8
			end
			`OFS_IRQ_FLAG_REG_SIX:
				rdata[`BIT_SINGLE_ERROR] = s.single_error_irq_flag;
			`OFS_IRQ_ENABLE_REG_SIX:
				rdata[`BIT_SINGLE_ERROR] = s.single_error_irq_enable;
			`OFS_IRQ_CONTROL_FOUR:
				rdata[`BIT_DOUBLE_ERROR] = s.double_error_flag;
			default: known = 1'b0;
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		next_s = s;
		next_s.pready = setup;
		if (setup) begin
			next_s.prdata = known && !pwrite ? rdata : 32'h00000000;
			next_s.pslverr = !known;
		end
		if (wr_access) begin
			// unlock window lasts for exactly one following write
			next_s.key_state = flash_ecc_pkg::KEY_IDLE;
			case (paddr)
				`OFS_UNLOCK_KEY: begin
					case (s.key_state)
						flash_ecc_pkg::KEY_IDLE:
							if (pwdata[7:0] == `KEY_FIRST)
								next_s.key_state =
									flash_ecc_pkg::KEY_HALF;
						flash_ecc_pkg::KEY_HALF:
							if (pwdata[7:0] == `KEY_SECOND)
								next_s.key_state =
									flash_ecc_pkg::KEY_OPEN; // R22
							else if (pwdata[7:0] == `KEY_FIRST)
								next_s.key_state =
									flash_ecc_pkg::KEY_HALF;
						default:
							if (pwdata[7:0] == `KEY_FIRST)
								next_s.key_state =
									flash_ecc_pkg::KEY_HALF;
					endcase
				end
				`OFS_INJECT_CONTROL:
					if (!pwdata[`BIT_INJECT_ENABLE])
						next_s.inject_enable = 1'b0; // R23
					else if (s.key_state == flash_ecc_pkg::KEY_OPEN)
						next_s.inject_enable = 1'b1; // R20 R22
				`OFS_INJECT_POINTERS: begin
					next_s.first_fault_pointer = pwdata[7:0];
					next_s.second_fault_pointer = pwdata[15:8]; // R18
				end
				`OFS_INJECT_ADDR_LOW:
					next_s.inject_compare_address[15:0] =
						pwdata[15:0]; // R19
				`OFS_INJECT_ADDR_HIGH:
					next_s.inject_compare_address[23:16] =
						pwdata[7:0]; // R19
				`OFS_IRQ_FLAG_REG_SIX:
					next_s.single_error_irq_flag =
						s.single_error_irq_flag &&
						pwdata[`BIT_SINGLE_ERROR];
				`OFS_IRQ_ENABLE_REG_SIX:
					next_s.single_error_irq_enable =
						pwdata[`BIT_SINGLE_ERROR];
				`OFS_IRQ_CONTROL_FOUR:
					next_s.double_error_flag = s.double_error_flag &&
						pwdata[`BIT_DOUBLE_ERROR];
				default: next_s.key_state = flash_ecc_pkg::KEY_IDLE;
			endcase
		end
		// read path
		next_s.rd_valid = rd_req;
		next_s.hard_trap = 1'b0;
		next_s.device_reset_request = 1'b0;
		if (rd_req) begin
			next_s.rd_data = err_single ?
				cw[47:0] ^ fix_mask(syn) : cw[47:0]; // R4 R5
			next_s.calc_single_parity = {1'b0, calc_sec}; // R7
			next_s.read_single_parity = {1'b0, cw[54:48]}; // R7
			next_s.error_syndrome = {1'b0, syn}; // R8
			next_s.calc_double_parity = calc_ded; // R11
			next_s.read_double_parity = cw[55]; // R11
			if (err_single)
				next_s.single_error_irq_flag = 1'b1; // R6
			if (err_double) begin
				next_s.double_error_flag = 1'b1; // R9
				next_s.hard_trap = 1'b1; // R9
				next_s.device_reset_request =
					!trap_handler_present; // R10
			end
		end
		next_s.single_error_irq = next_s.single_error_irq_flag &&
			next_s.single_error_irq_enable; // R6
		// write path
		next_s.array_we = wr_req;
		if (wr_req) begin
			next_s.array_addr = wr_addr;
			next_s.array_codeword = {^{wr_data, wr_sec}, wr_sec,
				wr_data} ^ (wr_hit ? inject_bits : 56'h0); // R2 R3 R14
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s <= '0;
			s.key_state <= flash_ecc_pkg::KEY_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	assign pready = s.pready;
	assign prdata = s.prdata;
	assign pslverr = s.pslverr;
	assign rd_valid = s.rd_valid;
	assign rd_data = s.rd_data;
	assign array_we = s.array_we;
	assign array_addr = s.array_addr;
	assign array_codeword = s.array_codeword;
	assign single_error_irq = s.single_error_irq;
	assign hard_trap = s.hard_trap;
	assign device_reset_request = s.device_reset_request;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	logic [47:0] raw_data;
	logic [6:0] raw_parity;
	logic raw_top;
	assign raw_data = cw[47:0];
	assign raw_parity = cw[54:48];
	assign raw_top = cw[55];

	read_answer_a: assert property (rd_req |=> rd_valid) // R4
		else $error("read not answered next cycle");
	double_raw_a: assert property (rd_req && err_double |=> // R5
		rd_data == $past(raw_data))
		else $error("double error data modified");
	clean_read_a: assert property (rd_req && !err_single && // R4
		!err_double |=> rd_data == $past(raw_data))
		else $error("clean read data changed");
	single_flag_a: assert property (rd_req && err_single |=> // R6
		s.single_error_irq_flag)
		else $error("single error flag not set");
	irq_gate_a: assert property (rd_req && err_single && // R6
		s.single_error_irq_enable && !wr_access |=>
		single_error_irq ##1 (single_error_irq || $past(wr_access)))
		else $error("single error irq missing");
	trap_flag_a: assert property (rd_req && err_double |=> // R9
		hard_trap && s.double_error_flag ##1
		(!hard_trap || $past(rd_req)))
		else $error("double error trap wrong");
	reset_req_a: assert property (rd_req && err_double && // R10
		!trap_handler_present |=> device_reset_request)
		else $error("device reset not requested");
	no_reset_a: assert property (rd_req && // R10
		trap_handler_present |=> !device_reset_request)
		else $error("reset requested with handler");
	clean_syn_a: assert property (rd_valid && // R8
		s.error_syndrome == 8'h00 &&
		s.calc_double_parity == s.read_double_parity |->
		s.calc_single_parity == s.read_single_parity)
		else $error("zero syndrome with unequal parity");
	read_parity_a: assert property (rd_req |=> // R7
		s.read_single_parity == {1'b0, $past(raw_parity)} &&
		s.read_double_parity == $past(raw_top))
		else $error("read parity status wrong");
	ded_equal_a: assert property (rd_req && !err_single && // R11
		!err_double |=> s.calc_double_parity == s.read_double_parity)
		else $error("double parity bits differ when clean");
	encode_a: assert property (wr_req && !wr_hit |=> array_we && // R2
		array_codeword[54:48] == hamming(array_codeword[47:0]))
		else $error("stored parity wrong");
	far_pointer_a: assert property (rd_req && // R17
		s.first_fault_pointer > `LAST_FAULT_BIT &&
		s.second_fault_pointer > `LAST_FAULT_BIT |->
		cw == rd_codeword)
		else $error("out of range pointer injected");
	enable_hold_a: assert property (s.inject_enable && // R23
		!(wr_access && paddr == `OFS_INJECT_CONTROL) |=>
		s.inject_enable)
		else $error("inject enable dropped");
	lock_a: assert property (wr_access && // R22
		paddr == `OFS_INJECT_CONTROL &&
		s.key_state != flash_ecc_pkg::KEY_OPEN && !s.inject_enable |=>
		!s.inject_enable)
		else $error("enable set without unlock");
	key_hidden_a: assert property (psel && !penable && // R21
		paddr == `OFS_UNLOCK_KEY |=> prdata == 32'h00000000)
		else $error("key register readable");
	control_zero_a: assert property (psel && !penable && // R20
		paddr == `OFS_INJECT_CONTROL |=> prdata[31:1] == 31'h0)
		else $error("control upper bits not zero");
	addr_high_a: assert property (psel && !penable && // R19
		paddr == `OFS_INJECT_ADDR_HIGH |=> prdata[31:8] == 24'h0)
		else $error("address high upper bits not zero");
	unmapped_err_a: assert property (psel && !penable && !known |=>
		pslverr)
		else $error("unmapped access not refused");
	apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb answer timing wrong");

	single_cov: cover property (rd_req && err_single);
	double_cov: cover property (rd_req && err_double);
	read_inject_cov: cover property (rd_hit);
	write_inject_cov: cover property (wr_hit);
	irq_cov: cover property (single_error_irq);
endmodule : flash_ecc_fault_injection
`default_nettype wire

//--- hw/flash_ecc_map.svh
// register offsets, field positions, reset values and keys of the ecc block
// assumes byte addressing on an apb bus with 32-bit words
`ifndef FLASH_ECC_MAP_SVH
`define FLASH_ECC_MAP_SVH
`define OFS_UNLOCK_KEY 8'h00
`define OFS_INJECT_CONTROL 8'h04
`define OFS_INJECT_POINTERS 8'h08
`define OFS_INJECT_ADDR_LOW 8'h0c
`define OFS_INJECT_ADDR_HIGH 8'h10
`define OFS_SINGLE_PARITY_STATUS 8'h14
`define OFS_DOUBLE_SYNDROME_STATUS 8'h18
`define OFS_IRQ_FLAG_REG_SIX 8'h1c
`define OFS_IRQ_ENABLE_REG_SIX 8'h20
`define OFS_IRQ_CONTROL_FOUR 8'h24
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define BIT_INJECT_ENABLE 0
`define BIT_SINGLE_ERROR 12
`define BIT_DOUBLE_ERROR 1
`define BIT_CALC_DOUBLE 9
`define BIT_READ_DOUBLE 8
`define LAST_FAULT_BIT 8'h37
`define RESET_BYTE 8'h00
`define RESET_ADDR 24'h000000
`endif

//--- hw/flash_ecc_pkg.sv
// types of the flash ecc and fault injection block
// assumes nothing beyond a systemverilog compiler
package flash_ecc_pkg;
	typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} key_state_t;
	typedef struct packed {
		key_state_t key_state;
		logic inject_enable;
		logic [7:0] first_fault_pointer;
		logic [7:0] second_fault_pointer;
		logic [23:0] inject_compare_address;
		logic [7:0] calc_single_parity;
		logic [7:0] read_single_parity;
		logic [7:0] error_syndrome;
		logic calc_double_parity;
		logic read_double_parity;
		logic single_error_irq_flag;
		logic single_error_irq_enable;
		logic double_error_flag;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic rd_valid;
		logic [47:0] rd_data;
		logic array_we;
		logic [23:0] array_addr;
		logic [55:0] array_codeword;
		logic single_error_irq;
		logic hard_trap;
		logic device_reset_request;
	} state_t;
endpackage : flash_ecc_pkg

//--- tb/flash_array_model.sv
// behavioural flash array: stores 56-bit ecc blocks, answers same cycle
// assumes the ecc block drives array_we as a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
	input wire logic clock,
	input wire logic rd_req,
	input wire logic [23:0] rd_addr,
	output logic [55:0] rd_codeword,
	input wire logic array_we,
	input wire logic [23:0] array_addr,
	input wire logic [55:0] array_codeword
);
	logic [55:0] mem [16];
	logic [55:0] last;
	// ==========
	// storage
	always @(posedge clock) begin
		if (array_we) mem[array_addr[3:0]] <= array_codeword;
		if (rd_req) last <= mem[rd_addr[3:0]];
	end
	// idle bus shows the inverse of the last word
	assign rd_codeword = rd_req ? mem[rd_addr[3:0]] : ~last;
endmodule : flash_array_model
`default_nettype wire

//--- tb/flash_ecc_fault_injection_bench.sv
// bench of the flash ecc block: registers, correction, fault injection
// assumes the design files under hw/ and the flash array model
`timescale 1ns/10ps
`default_nettype none
module flash_ecc_fault_injection_bench;
	logic clock, rst_n, psel, penable, pwrite, rd_req, wr_req, thp;
	logic pready, pslverr, rd_valid, array_we, irq, trap, rreq, rerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [23:0] rd_addr, wr_addr, array_addr;
	logic [55:0] rd_codeword, array_codeword, e;
	logic [47:0] rd_data, wr_data;
	int miscompares, checks_done, cyc;
	localparam logic [47:0] D = 48'h5a5a_1234_c3c3;
	localparam logic [23:0] TA = 24'h123405;
	flash_ecc_fault_injection i_dut (.clock(clock), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_codeword(rd_codeword), .rd_valid(rd_valid), .rd_data(rd_data),
		.wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
		.array_we(array_we), .array_addr(array_addr),
		.array_codeword(array_codeword), .trap_handler_present(thp),
		.single_error_irq(irq), .hard_trap(trap),
		.device_reset_request(rreq));
	flash_array_model i_mem (.clock(clock), .rd_req(rd_req),
		.rd_addr(rd_addr), .rd_codeword(rd_codeword), .array_we(array_we),
		.array_addr(array_addr), .array_codeword(array_codeword));
	// ==========
	// helpers
	function automatic logic [55:0] enc(input logic [47:0] d);
		logic [6:0] h;
		int k;
		h = 7'h00;
		k = 0;
		for (int p = 3; k < 48; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (d[k]) h ^= p[6:0];
				k++;
			end
		end
		return {^{d, h}, h, d};
	endfunction : enc
	task chk(input string nm, input logic [63:0] x, input logic [63:0] g);
		checks_done++;
		if (g !== x) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task fl(input logic w, input logic [23:0] a, input logic [47:0] d);
		@(posedge clock);
		rd_req <= !w;
		wr_req <= w;
		rd_addr <= a;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clock);
		rd_req <= 1'b0;
		wr_req <= 1'b0;
		#1;
	endtask : fl
	task arm(input logic [15:0] ptrs);
		apb(1'b1, 8'h0c, {16'h0000, TA[15:0]});
		apb(1'b1, 8'h10, {24'h000000, TA[23:16]});
		apb(1'b1, 8'h08, {16'h0000, ptrs});
		apb(1'b1, 8'h00, 32'h00000055);
		apb(1'b1, 8'h00, 32'h000000aa);
		apb(1'b1, 8'h04, 32'h00000001);
	endtask : arm
	// ==========
	// scenarios
	task t_regs;
		for (int a = 0; a < 10; a++) begin
			apb(1'b0, 8'(a * 4), 32'h0);
			chk("reset value", 32'h0, rdat);
		end
		apb(1'b0, 8'h28, 32'h0);
		chk("unmapped error", 1'b1, rerr);
		apb(1'b1, 8'h04, 32'h1);
		apb(1'b0, 8'h04, 32'h0);
		chk("locked enable", 32'h0, rdat);
		apb(1'b1, 8'h10, 32'hffffffff);
		apb(1'b0, 8'h10, 32'h0);
		chk("addr high", 32'h00ff, rdat);
		apb(1'b1, 8'h00, 32'h1234);
		apb(1'b0, 8'h00, 32'h0);
		chk("key read", 32'h0, rdat);
	endtask : t_regs
	task t_clean;
		e = enc(D);
		fl(1'b1, 24'h3, D);
		chk("stored block", e, array_codeword);
		fl(1'b1, TA, D);
		fl(1'b0, 24'h3, 48'h0);
		chk("clean data", D, rd_data);
		apb(1'b0, 8'h14, 32'h0);
		chk("parity status", {17'h0, e[54:48], 1'b0, e[54:48]}, rdat);
		apb(1'b0, 8'h18, 32'h0);
		chk("syndrome status", {22'h0, e[55], e[55], 8'h0}, rdat);
	endtask : t_clean
	task t_single;
		logic [55:0] g;
		g = enc(D);
		arm(16'hff05);
		fl(1'b0, TA, 48'h0);
		chk("corrected", D, rd_data);
		chk("no trap", 1'b0, trap);
		e = enc(48'h20);
		apb(1'b0, 8'h18, 32'h0);
		chk("syndrome", {22'h0, ~g[55], g[55], 1'b0, e[54:48]}, rdat);
		apb(1'b0, 8'h1c, 32'h0);
		chk("single flag", 32'h1000, rdat);
		apb(1'b1, 8'h20, 32'h1000);
		#1;
		chk("irq raised", 1'b1, irq);
		fl(1'b0, TA, 48'h0);
		chk("corrected again", D, rd_data);
		chk("irq held", 1'b1, irq);
		apb(1'b1, 8'h1c, 32'h0);
		#1;
		chk("irq cleared", 1'b0, irq);
		apb(1'b0, 8'h04, 32'h0);
		chk("enable kept", 32'h1, rdat);
		apb(1'b1, 8'h08, 32'h0000ff38);
		fl(1'b0, TA, 48'h0);
		chk("far pointer data", D, rd_data);
		apb(1'b0, 8'h18, 32'h0);
		chk("far pointer status", {22'h0, g[55], g[55], 8'h0}, rdat);
	endtask : t_single
	task t_double;
		arm(16'h0702);
		fl(1'b1, TA, D);
		chk("injected write", enc(D) ^ 56'h84, array_codeword);
		apb(1'b1, 8'h04, 32'h0);
		fl(1'b0, TA, 48'h0);
		chk("raw data", D ^ 48'h84, rd_data);
		chk("hard trap", 1'b1, trap);
		chk("reset request", 1'b1, rreq);
		apb(1'b0, 8'h24, 32'h0);
		chk("double flag", 32'h2, rdat);
		thp <= 1'b1;
		fl(1'b0, TA, 48'h0);
		chk("trap with handler", 1'b1, trap);
		chk("no reset request", 1'b0, rreq);
	endtask : t_double
	task t_reset;
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		apb(1'b0, 8'h24, 32'h0);
		chk("double flag after reset", 32'h0, rdat);
		apb(1'b0, 8'h10, 32'h0);
		chk("addr high after reset", 32'h0, rdat);
	endtask : t_reset
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// ==========
	// clock, timeout, sequence
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			complete_run;
		end
	end
	initial begin
		{rst_n, psel, penable, pwrite, rd_req, wr_req, thp} = 7'h0;
		{paddr, pwdata, rd_addr, wr_addr, wr_data} = '0;
		miscompares = 0;
		checks_done = 0;
		cyc = 0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		t_regs;
		t_clean;
		t_single;
		t_double;
		t_reset;
		complete_run;
	end
endmodule : flash_ecc_fault_injection_bench
`default_nettype wire
